// ---- ccr_pkg.sv ----
// Shared constants for the codec clock and reference control block.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
package ccr_pkg;

	// ----------------------------------------------------------------
	// Clock rate and timing
	// ----------------------------------------------------------------
	localparam int unsigned PCLK_MHZ        = 200;   // pclk rate
	localparam int unsigned MCLK_WIN_NS     = 2000;  // detector window
	localparam int unsigned MCLK_WIN_CYC    = (MCLK_WIN_NS * PCLK_MHZ) / 1000;
	localparam int unsigned MCLK_MIN_EDGES  = 2;     // 1 MHz over 2 us
	localparam int unsigned REF_SETTLE_US   = 10000; // bandgap charge time
	localparam int unsigned REF_SETTLE_CYC  = REF_SETTLE_US * PCLK_MHZ;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL     = 12'h000; // mode, divider, refs
	localparam logic [11:0] OFS_FB_INT   = 12'h004; // feedback integer
	localparam logic [11:0] OFS_FRAC_TOP = 12'h008; // fraction MSBs
	localparam logic [11:0] OFS_FRAC_BOT = 12'h00c; // fraction LSBs
	localparam logic [11:0] OFS_RATE     = 12'h010; // sample rate code
	localparam logic [11:0] OFS_SUBEN    = 12'h014; // sub-block enables
	localparam logic [11:0] OFS_STATUS   = 12'h018; // read-only status

	// ----------------------------------------------------------------
	// Control register fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_MODE_LSB  = 0;  // 2-bit clock mode
	localparam int unsigned CTRL_INDIV_LSB = 2;  // 3-bit input divider
	localparam int unsigned CTRL_ACTIVE    = 5;  // active / standby
	localparam int unsigned CTRL_FASTCHG   = 6;  // mid-rail quick charge
	localparam int unsigned CTRL_BIAS      = 7;  // master bias enable
	localparam int unsigned CTRL_IOLVL     = 8;  // pad voltage range
	localparam int unsigned CTRL_W         = 9;
	localparam logic [8:0]  CTRL_RST       = 9'h080; // bias on
	localparam int unsigned FB_INT_W       = 7;
	localparam int unsigned FRAC_TOP_W     = 8;
	localparam int unsigned FRAC_BOT_W     = 5;
	localparam int unsigned FB_W           = 20; // 7 int + 13 frac
	localparam int unsigned SUBSYS_N       = 4;  // subsystems
	localparam int unsigned SUBBLK_N       = 4;  // sub-blocks each
	localparam logic [3:0]  RATE_RST       = 4'hb; // 48 kHz

	// ----------------------------------------------------------------
	// Clock mode codes and source selects
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_BYPASS = 2'h0;
	localparam logic [1:0] MODE_NORMAL = 2'h1;
	localparam logic [1:0] MODE_TRACK  = 2'h2;
	localparam logic [1:0] MODE_RSVD   = 2'h3;
	localparam logic [1:0] SRC_MCLK    = 2'h0; // bypass
	localparam logic [1:0] SRC_PLL     = 2'h1;
	localparam logic [1:0] SRC_OSC     = 2'h2;

	// Clock source state machine
	typedef enum logic [1:0] {
		ST_OSC,
		ST_BYPASS,
		ST_LOCKWAIT,
		ST_PLL
	} ccr_src_e;

endpackage

// ---- ccr_clk_detect.sv ----
// Master clock presence detector: counts edges of a pin clock.
// Assumes the pin is asynchronous to pclk and slower than pclk / 2.
`timescale 1ns/100ps
module ccr_clk_detect
	import ccr_pkg::*;
(
	// Clock, reset and enable
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Pin clock and verdict
	input  wire logic clk_pin,
	output logic      present
);

	logic [1:0]  sync_r;  // two-stage synchroniser
	logic        last_r;  // previous synced level
	logic [15:0] win_r;   // window countdown
	logic [3:0]  edge_r;  // edges seen this window

	// ----------------------------------------------------------------
	// Synchroniser and edge history
	// ----------------------------------------------------------------
	// Only the second stage feeds the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_r <= 2'h0;
			last_r <= 1'h0;
		end else if (ce) begin
			sync_r <= {sync_r[0], clk_pin};
			last_r <= sync_r[1];
		end
	end

	// ----------------------------------------------------------------
	// Windowed edge count
	// ----------------------------------------------------------------
	// A stopped clock fails by the end of the next window, so loss shows within 4 us
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_r   <= 16'h0;
			edge_r  <= 4'h0;
			present <= 1'h0;
		end else if (ce) begin
			if (win_r == 16'h0) begin
				// Window end: judge and restart
				present <= (edge_r >= 4'(MCLK_MIN_EDGES));
				win_r   <= 16'(MCLK_WIN_CYC - 1);
				edge_r  <= 4'h0;
			end else begin
				win_r <= win_r - 16'h1;
				// Saturate, only the threshold matters
				if (sync_r[1] && !last_r && edge_r != 4'hf)
					edge_r <= edge_r + 4'h1;
			end
		end
	end

endmodule // ccr_clk_detect

// ---- ccr_top.sv ----
// Codec clock source selection and reference enable control.
// Assumes an APB master on pclk; mclk, wclk and pll lock are pins.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ccr_top
	import ccr_pkg::*;
#(
	parameter int unsigned REF_SETTLE = REF_SETTLE_CYC // shorten in sim
) (
	// Clock, reset and enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins from outside the pclk domain
	input  wire logic        mclk_pin,
	input  wire logic        wclk_pin,
	input  wire logic        pll_lock_pin,
	// PLL controls
	output logic             pll_en,
	output logic             pll_rst,
	output logic             pll_track_wclk,
	output logic             pll_in_mclk,
	output logic      [2:0]  pll_indiv,
	output logic      [19:0] pll_fbdiv,
	// Core clock selection
	output logic      [1:0]  core_clock_src,
	output logic             core_clock_fast,
	output logic             osc_en,
	// References, bias and pads
	output logic             vref_en,
	output logic             vmid_en,
	output logic             vmid_fast_charge,
	output logic             ref_ready,
	output logic             master_bias_en,
	output logic      [3:0]  local_bias_en,
	output logic      [15:0] subblk_en,
	output logic             io_low_range
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge for partial APB writes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	// Rate code family: 1 for 48 kHz family, 0 for 44.1 kHz
	function automatic logic [1:0] rate_family(input logic [3:0] code);
		logic [1:0] fam; // {valid, fast}
		fam = 2'h0;
		case (code)
			4'h1, 4'h3, 4'h5, 4'h7,
			4'h9, 4'hb, 4'hf: fam = 2'h3;
			4'h2, 4'h6, 4'ha, 4'he: fam = 2'h2;
			default: fam = 2'h0;
		endcase
		return fam;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0]     ctrl_r;      // control word
	logic [FB_INT_W-1:0]   fb_int_r;    // feedback integer
	logic [FRAC_TOP_W-1:0] frac_top_r;  // fraction MSBs
	logic [FRAC_BOT_W-1:0] frac_bot_r;  // fraction LSBs
	logic [3:0]            rate_r;      // sample rate code
	logic [15:0]           suben_r;     // sub-block enables
	logic [1:0]            lock_sync_r; // lock pin synchroniser
	logic [1:0]            wclk_sync_r; // word clock synchroniser
	logic                  wclk_last_r; // word clock history
	logic [15:0]           wclk_idle_r; // cycles since word edge
	logic                  fb_int_wr_r; // integer write event
	logic                  relock_r;    // stale lock guard
	logic [31:0]           settle_r;    // reference settle timer
	ccr_src_e              src_r;       // clock source state
	ccr_src_e              src_nxt;     // next state
	logic                  mclk_ok;     // master clock present
	logic                  wr_en;       // write commits now
	logic                  setup;       // setup phase
	logic [31:0]           rd_mux;      // read data select
	logic                  hit;         // mapped address
	logic [1:0]            mode;        // clock mode field
	logic                  active;      // active mode
	logic                  locked;      // synced pll lock

	assign mode   = ctrl_r[CTRL_MODE_LSB +: 2];
	assign active = ctrl_r[CTRL_ACTIVE];
	assign locked = lock_sync_r[1];

	// ----------------------------------------------------------------
	// Master clock detector
	// ----------------------------------------------------------------
	ccr_clk_detect u_mclk_det (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.clk_pin (mclk_pin),
		.present (mclk_ok)
	);

	// ----------------------------------------------------------------
	// APB slave: no wait states, registered answer
	// ----------------------------------------------------------------
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;

	// Address decode for reads and the unmapped check
	always_comb begin
		rd_mux = 32'h0;
		hit    = 1'h1;
		case (paddr)
			OFS_CTRL:     rd_mux = 32'(ctrl_r);
			OFS_FB_INT:   rd_mux = 32'(fb_int_r);
			OFS_FRAC_TOP: rd_mux = 32'(frac_top_r);
			OFS_FRAC_BOT: rd_mux = 32'(frac_bot_r);
			OFS_RATE:     rd_mux = 32'(rate_r);
			OFS_SUBEN:    rd_mux = 32'(suben_r);
			OFS_STATUS:   rd_mux = {24'h0, src_r == ST_PLL &&
				mode == MODE_TRACK, osc_en, core_clock_fast, ref_ready,
				core_clock_src, locked, mclk_ok};
			default: hit = 1'h0;
		endcase
	end

	// Answer is prepared in setup and shown in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h0;
		end else if (ce) begin
			pready  <= setup;
			pslverr <= setup && !hit;
			// Writes read back zero, reads get the decoded word
			prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Status is read-only; writes to it are silently dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= CTRL_RST;   // master bias on
			fb_int_r   <= '0;
			frac_top_r <= '0;
			frac_bot_r <= '0;
			rate_r     <= RATE_RST;
			suben_r    <= 16'h0;
		end else if (ce && wr_en) begin
			case (paddr)
				OFS_CTRL: ctrl_r <=
					CTRL_W'(merge(32'(ctrl_r), pwdata, pstrb));
				OFS_FB_INT: fb_int_r <=
					FB_INT_W'(merge(32'(fb_int_r), pwdata, pstrb));
				OFS_FRAC_TOP: frac_top_r <=
					FRAC_TOP_W'(merge(32'(frac_top_r), pwdata, pstrb));
				OFS_FRAC_BOT: frac_bot_r <=
					FRAC_BOT_W'(merge(32'(frac_bot_r), pwdata, pstrb));
				OFS_RATE: begin
					// Unlisted rate codes are ignored
					if (pstrb[0] && rate_family(pwdata[3:0]) != 2'h0)
						rate_r <= pwdata[3:0];
				end
				OFS_SUBEN: suben_r <=
					16'(merge(32'(suben_r), pwdata, pstrb));
				default: ;
			endcase
		end
	end

	// Any write to the integer word restarts lock, even same value;
	// old lock lingers in the synchroniser, so wait for it to drop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_int_wr_r <= 1'h0;
			relock_r    <= 1'h0;
		end else if (ce) begin
			fb_int_wr_r <= wr_en && paddr == OFS_FB_INT;
			relock_r    <= fb_int_wr_r || (relock_r && locked);
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Word clock counted idle; 16 bits outlast its slowest half period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_sync_r <= 2'h0;
			wclk_sync_r <= 2'h0;
			wclk_last_r <= 1'h0;
			wclk_idle_r <= '1;
		end else if (ce) begin
			lock_sync_r <= {lock_sync_r[0], pll_lock_pin};
			wclk_sync_r <= {wclk_sync_r[0], wclk_pin};
			wclk_last_r <= wclk_sync_r[1];
			if (wclk_sync_r[1] != wclk_last_r)
				wclk_idle_r <= '0;
			else if (wclk_idle_r != '1)
				wclk_idle_r <= wclk_idle_r + 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// Clock source state machine
	// ----------------------------------------------------------------
	always_comb begin
		src_nxt = src_r;
		if (!mclk_ok) begin
			src_nxt = ST_OSC;
		end else begin
			case (mode)
				MODE_BYPASS: src_nxt = ST_BYPASS;
				MODE_NORMAL, MODE_TRACK: begin
					// Hold bypass clock until lock
					if (fb_int_wr_r || src_r == ST_OSC)
						src_nxt = ST_LOCKWAIT;
					else if (src_r == ST_BYPASS)
						src_nxt = ST_LOCKWAIT;
					else if (src_r == ST_LOCKWAIT && locked && !relock_r)
						src_nxt = ST_PLL;
					else if (src_r == ST_PLL && !locked)
						src_nxt = ST_LOCKWAIT;
				end
				default:   src_nxt = src_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			src_r <= ST_OSC;
		else if (ce)
			src_r <= src_nxt;
	end

	// ----------------------------------------------------------------
	// PLL and core clock outputs
	// ----------------------------------------------------------------
	// A write to the integer word gives one reset pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_en          <= 1'h0;
			pll_rst         <= 1'h1;
			pll_track_wclk  <= 1'h0;
			pll_in_mclk     <= 1'h0;
			pll_indiv       <= 3'h0;
			pll_fbdiv       <= 20'h0;
			core_clock_src  <= SRC_OSC;
			core_clock_fast <= 1'h1;
		end else if (ce) begin
			pll_en <= src_nxt == ST_LOCKWAIT || src_nxt == ST_PLL;
			pll_rst <= fb_int_wr_r ||
				!(src_nxt == ST_LOCKWAIT || src_nxt == ST_PLL);
			// Word clock reference only while it toggles
			pll_track_wclk <= mode == MODE_TRACK && wclk_idle_r != '1;
			pll_in_mclk <= mclk_ok;
			// Divided reference 2-5 MHz for 2-54 MHz input
			pll_indiv <= ctrl_r[CTRL_INDIV_LSB +: 3];
			// Integer, then 8 + 5 fraction bits
			pll_fbdiv <= {fb_int_r, frac_top_r, frac_bot_r};
			case (src_nxt)
				ST_PLL:    core_clock_src <= SRC_PLL;
				ST_OSC:    core_clock_src <= SRC_OSC;
				default:   core_clock_src <= SRC_MCLK;
			endcase
			core_clock_fast <= rate_family(rate_r) == 2'h3;
		end
	end

	// ----------------------------------------------------------------
	// References, oscillator and settle timer
	// ----------------------------------------------------------------
	// Timer restarts each time the device leaves standby
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_r  <= 32'h0;
			ref_ready <= 1'h0;
		end else if (ce) begin
			if (!active) begin
				settle_r  <= 32'h0;
				ref_ready <= 1'h0;
			end else if (settle_r < REF_SETTLE - 1) begin
				settle_r <= settle_r + 32'h1;
			end else begin
				ref_ready <= 1'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vref_en          <= 1'h0;
			vmid_en          <= 1'h0;
			vmid_fast_charge <= 1'h0;
			osc_en           <= 1'h0;
		end else if (ce) begin
			vref_en <= active;
			vmid_en <= active;
			// Software owns clearing it after start-up
			vmid_fast_charge <= ctrl_r[CTRL_FASTCHG] && active;
			osc_en <= active && !mclk_ok;
		end
	end

	// ----------------------------------------------------------------
	// Bias and pad range
	// ----------------------------------------------------------------
	// Sub-blocks wait for the reference; local bias follows their enable bits at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_bias_en <= 1'h1;
			local_bias_en  <= 4'h0;
			subblk_en      <= 16'h0;
			io_low_range   <= 1'h0;
		end else if (ce) begin
			master_bias_en <= ctrl_r[CTRL_BIAS];
			for (int s = 0; s < SUBSYS_N; s++)
				local_bias_en[s] <=
					|suben_r[s*SUBBLK_N +: SUBBLK_N];
			subblk_en    <= ref_ready ? suben_r : 16'h0;
			io_low_range <= ctrl_r[CTRL_IOLVL];
		end
	end

endmodule // ccr_top

// ---- ccr_asserts.sv ----
// Concurrent checks on the clock and reference control top ports.
// Assumes it is bound to ccr_top and sees only that module's ports.
`timescale 1ns/100ps
module ccr_asserts
	import ccr_pkg::*;
#(
	parameter int unsigned REF_SETTLE = 20 // Settle timer, at least 9
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Clocking
	input wire logic        pll_en,
	input wire logic        pll_in_mclk,
	input wire logic [1:0]  core_clock_src,
	input wire logic        osc_en,
	// References and bias
	input wire logic        vref_en,
	input wire logic        vmid_en,
	input wire logic        vmid_fast_charge,
	input wire logic        ref_ready,
	input wire logic [3:0]  local_bias_en,
	input wire logic [15:0] subblk_en
);
	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	chk_refs_pair: assert property (vref_en == vmid_en)
		else $error("references disagree");
	chk_fast_active: assert property (vmid_fast_charge |-> vmid_en)
		else $error("quick charge in standby");
	// Timer must hold users off for at least eight cycles
	chk_settle_hold: assert property ($rose(vref_en) |-> !ref_ready [*8])
		else $error("reference ready too early");
	chk_users_gated: assert property ((subblk_en != 16'h0) |->
		ref_ready || $past(ref_ready))
		else $error("sub-block on before reference ready");
	chk_local_bias: assert property ((|subblk_en[7:4]) |-> local_bias_en[1])
		else $error("local bias off with sub-block on");
	// Two cycles of slack for the source state machine
	chk_osc_fallback: assert property (!pll_in_mclk [*3] |->
		core_clock_src == SRC_OSC)
		else $error("no fallback to oscillator");
	chk_osc_off_mclk: assert property (pll_in_mclk [*3] |-> !osc_en)
		else $error("oscillator on with master clock");
	chk_pll_powered: assert property (core_clock_src == SRC_PLL |-> pll_en)
		else $error("PLL source while PLL off");

	cover property (core_clock_src == SRC_PLL);
	cover property (pslverr);
	cover property (ref_ready && subblk_en != 16'h0);

endmodule // ccr_asserts

bind ccr_top ccr_asserts #(.REF_SETTLE(REF_SETTLE)) u_ccr_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pll_en(pll_en), .pll_in_mclk(pll_in_mclk),
	.core_clock_src(core_clock_src), .osc_en(osc_en),
	.vref_en(vref_en), .vmid_en(vmid_en),
	.vmid_fast_charge(vmid_fast_charge), .ref_ready(ref_ready),
	.local_bias_en(local_bias_en), .subblk_en(subblk_en));

// ---- ccr_clk_partner.sv ----
// Model of the master clock source, word clock and analog PLL lock.
// Assumes pclk at 200 MHz; run inputs come from the bench.
`timescale 1ns/100ps
module ccr_clk_partner (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench controls
	input wire logic mclk_run,
	input wire logic wclk_run,
	input wire logic lock_slow,
	// PLL controls from the block
	input wire logic pll_en,
	input wire logic pll_rst,
	// Pins
	output logic     mclk_pin,
	output logic     wclk_pin,
	output logic     pll_lock_pin
);
	int cnt; // Cycles since PLL released

	// 50 MHz, inside the PLL input range; parked low when stopped
	initial begin
		mclk_pin = 1'h0;
		forever #10 mclk_pin = mclk_run ? ~mclk_pin : 1'h0;
	end
	initial begin
		wclk_pin = 1'h0;
		forever #100 wclk_pin = wclk_run ? ~wclk_pin : 1'h0;
	end

	// Lock after a prompt or slow delay; reset drops it at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt          <= 0;
			pll_lock_pin <= 1'h0;
		end else if (!pll_en || pll_rst) begin
			cnt          <= 0;
			pll_lock_pin <= 1'h0;
		end else begin
			cnt          <= cnt + 1;
			pll_lock_pin <= cnt >= (lock_slow ? 200 : 10);
		end
	end

endmodule // ccr_clk_partner

// ---- ccr_top_tb.sv ----
// Self-checking bench for the clock and reference control top.
// Assumes ccr_clk_partner and the bound checker are compiled alongside.
`timescale 1ns/100ps
module ccr_top_tb
	import ccr_pkg::*;
;
	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [3:0]  pstrb, local_bias_en, cur;
	logic        mclk_pin, wclk_pin, pll_lock_pin, pll_en, pll_rst;
	logic        pll_track_wclk, pll_in_mclk, core_clock_fast, osc_en;
	logic        vref_en, vmid_en, vmid_fast_charge, ref_ready;
	logic        master_bias_en, io_low_range, err_v, seen;
	logic [2:0]  pll_indiv;
	logic [19:0] pll_fbdiv;
	logic [1:0]  core_clock_src;
	logic [15:0] subblk_en;
	logic        mclk_run, wclk_run, lock_slow; // Partner controls
	int          fail_count, compares;
	localparam logic [15:0] RATE_OK   = 16'hceee; // Listed rate codes
	localparam logic [15:0] RATE_FAST = 16'h8aaa; // 48 kHz family codes

	// Settle timer shortened to keep the run brief
	ccr_top #(.REF_SETTLE(20)) u_ccr_top (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mclk_pin(mclk_pin),
		.wclk_pin(wclk_pin), .pll_lock_pin(pll_lock_pin), .pll_en(pll_en),
		.pll_rst(pll_rst), .pll_track_wclk(pll_track_wclk),
		.pll_in_mclk(pll_in_mclk), .pll_indiv(pll_indiv),
		.pll_fbdiv(pll_fbdiv), .core_clock_src(core_clock_src),
		.core_clock_fast(core_clock_fast), .osc_en(osc_en),
		.vref_en(vref_en), .vmid_en(vmid_en),
		.vmid_fast_charge(vmid_fast_charge), .ref_ready(ref_ready),
		.master_bias_en(master_bias_en), .local_bias_en(local_bias_en),
		.subblk_en(subblk_en), .io_low_range(io_low_range));

	ccr_clk_partner u_ccr_clk_partner (.pclk(pclk), .presetn(presetn),
		.mclk_run(mclk_run), .wclk_run(wclk_run), .lock_slow(lock_slow),
		.pll_en(pll_en), .pll_rst(pll_rst), .mclk_pin(mclk_pin),
		.wclk_pin(wclk_pin), .pll_lock_pin(pll_lock_pin));

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask

	// One APB transfer; waits for ready, bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) chk(32'h1, 32'h0);
		r = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d, rd_v, err_v);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0, rd_v, err_v);
		chk(rd_v, x);
	endtask

	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask

	// Bounded wait for a core clock source, then compare
	task automatic wait_src(input logic [1:0] x);
		int n;
		n = 0;
		while (core_clock_src !== x && n < 1200) begin
			@(posedge pclk);
			n++;
		end
		chk(core_clock_src, x);
	endtask

	task automatic results();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Clock, watchdog and tests
	// -----------------------------------------------------------------
	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end

	// Tests need under 2500 cycles; 100 us allows 20000, eight times that
	initial begin
		#100us;
		fail_count++;
		results();
	end

	initial begin
		fail_count = 0;
		compares = 0;
		{presetn, psel, penable, pwrite, mclk_run, wclk_run, lock_slow} = '0;
		ce = 1'h1;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		chk(core_clock_src, SRC_OSC);
		chk(master_bias_en, 32'h1);
		rd(OFS_CTRL, 32'h80);
		rd(OFS_RATE, 32'hb);
		// Active with quick charge, no master clock yet
		wr(OFS_CTRL, 32'h0e0);
		wr(OFS_SUBEN, 32'h12);
		settle();
		chk(vref_en, 32'h1);
		chk(vmid_fast_charge, 32'h1);
		chk(osc_en, 32'h1);
		chk(subblk_en, 32'h0);
		chk(local_bias_en, 32'h3);
		repeat (25) @(posedge pclk);
		chk(ref_ready, 32'h1);
		chk(subblk_en, 32'h12);
		wr(OFS_CTRL, 32'h1a0);
		settle();
		chk(vmid_fast_charge, 32'h0);
		chk(io_low_range, 32'h1);
		wr(OFS_CTRL, 32'h0a0);
		settle();
		chk(io_low_range, 32'h0);
		// Every rate code; unlisted ones leave the rate alone
		cur = 4'hb;
		for (int i = 0; i < 16; i++) begin
			wr(OFS_RATE, i);
			if (RATE_OK[i]) cur = i[3:0];
			rd(OFS_RATE, cur);
			settle();
			chk(core_clock_fast, RATE_FAST[cur]);
		end
		// Master clock arrives: window is 400 cycles, two windows max
		mclk_run <= 1'h1;
		repeat (850) @(posedge pclk);
		chk(pll_in_mclk, 32'h1);
		chk(osc_en, 32'h0);
		wait_src(SRC_MCLK);
		rd(OFS_STATUS, 32'h31);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_CTRL, 32'h0a0 | (i << 2));
			settle();
			chk(pll_indiv, i);
		end
		wr(OFS_FB_INT, 32'h7f);
		wr(OFS_FRAC_TOP, 32'hc3);
		wr(OFS_FRAC_BOT, 32'h15);
		settle();
		chk(pll_fbdiv, {7'h7f, 8'hc3, 5'h15});
		// Normal mode, slow lock: bypass clock kept meanwhile
		lock_slow <= 1'h1;
		wr(OFS_CTRL, 32'h0a9);
		repeat (20) @(posedge pclk);
		chk(core_clock_src, SRC_MCLK);
		chk(pll_en, 32'h1);
		wait_src(SRC_PLL);
		lock_slow <= 1'h0;
		wr(OFS_FB_INT, 32'h20);
		seen = 1'h0;
		repeat (8) begin
			@(posedge pclk);
			seen |= pll_rst;
			if (seen) chk(core_clock_src, SRC_MCLK);
		end
		chk(seen, 32'h1);
		wait_src(SRC_PLL);
		wr(OFS_CTRL, 32'h0ab);
		repeat (20) @(posedge pclk);
		chk(core_clock_src, SRC_PLL);
		// Tracking, then relock, master clock loss, standby and unmapped accesses
		wclk_run <= 1'h1;
		wr(OFS_CTRL, 32'h0aa);
		wait_src(SRC_PLL);
		repeat (50) @(posedge pclk);
		chk(pll_track_wclk, 32'h1);
		rd(OFS_STATUS, 32'hb7);
		wr(OFS_CTRL, 32'h0a8);
		wr(OFS_FB_INT, 32'h20);
		wr(OFS_CTRL, 32'h0aa);
		wait_src(SRC_PLL);
		wr(OFS_CTRL, 32'h0a0);
		wait_src(SRC_MCLK);
		chk(pll_en, 32'h0);
		mclk_run <= 1'h0;
		wait_src(SRC_OSC);
		settle();
		chk(osc_en, 32'h1);
		wr(OFS_CTRL, 32'h080);
		settle();
		chk(vref_en, 32'h0);
		chk(ref_ready, 32'h0);
		chk(osc_en, 32'h0);
		apb(1'h0, 12'h01c, 32'h0, rd_v, err_v);
		chk(err_v, 32'h1);
		chk(rd_v, 32'h0);
		apb(1'h1, 12'h020, 32'h5, rd_v, err_v);
		chk(err_v, 32'h1);
		results();
	end

endmodule // ccr_top_tb
